// [inc/hmw_regs.svh]
`ifndef HMW_REGS_SVH
`define HMW_REGS_SVH
// Host I/O offsets of the window registers.
`define HMW_OFF_BANK_SEL 6'h01
`define HMW_OFF_PTR_LO 6'h02
`define HMW_OFF_PTR_HI 6'h03
// First and last of the four aliased data ports.
`define HMW_OFF_DP_FIRST 6'h04
`define HMW_OFF_DP_LAST 6'h07
// Transceiver windows, narrow and wide.
`define HMW_OFF_TRX_LO 6'h08
`define HMW_OFF_TRX_NARROW_HI 6'h0F
`define HMW_OFF_TRX_WIDE_HI 6'h27
// Field positions of the bank switch select register.
`define HMW_SEL_CAPTURE 7
`define HMW_SEL_FLASH 5
`define HMW_SEL_MBANK_HI 4
`define HMW_SEL_MBANK_LO 3
`define HMW_SEL_WIDE 2
`define HMW_SEL_TBANK_HI 1
`define HMW_SEL_TBANK_LO 0
// Sleep request bit of the upper pointer register.
`define HMW_PTR_HI_SLEEP 7
// Reset value of the control bits.
`define HMW_SEL_RST 8'h00
`endif

// [inc/hmw_pkg.sv]
package hmw_pkg;
  // Host pin group as sampled from the bus.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } hmw_host_t;
  // Request issued to the local memory bus.
  typedef struct packed {
    logic req;
    logic we;
    logic flash;
    logic [16:0] addr;
    logic [7:0] wdata;
  } hmw_mem_t;
  // Request issued to the transceiver registers.
  typedef struct packed {
    logic req;
    logic we;
    logic [4:0] index;
    logic [7:0] wdata;
  } hmw_trx_t;
endpackage : hmw_pkg

// [design/hmw_top.sv]
`timescale 1ns/1ps
`include "hmw_regs.svh"
module hmw_top #(
  parameter int PTR_W = 15
) (
  input wire logic mclk,
  input wire logic rst,
  input wire hmw_pkg::hmw_host_t host_pins,
  input wire logic isa_mode,
  input wire logic core_ale,
  input wire logic core_sleep_clr,
  input wire logic pd_active,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] trx_rdata,
  output hmw_pkg::hmw_mem_t mem_out,
  output hmw_pkg::hmw_trx_t trx_out,
  output logic [7:0] host_rdata,
  output logic core_sleep_flag,
  output logic core_irq,
  output logic pd_exit
);
  import hmw_pkg::*;

  // The address map is laid out for a 15-bit pointer only.
  if (PTR_W != 15) begin : g_chk
    $error("hmw_top supports PTR_W of 15 only");
  end

  // Is the offset one of the four aliased data ports.
  function automatic logic is_dport(input logic [5:0] off);
    is_dport = (off >= `HMW_OFF_DP_FIRST) && (off <= `HMW_OFF_DP_LAST);
  endfunction : is_dport

  // Transceiver hit for the present window size.
  function automatic logic is_trx(input logic [5:0] off, input logic wide);
    if (wide) begin
      is_trx = (off >= `HMW_OFF_TRX_LO) && (off <= `HMW_OFF_TRX_WIDE_HI);
    end else begin
      is_trx = (off >= `HMW_OFF_TRX_LO) && (off <= `HMW_OFF_TRX_NARROW_HI);
    end
  endfunction : is_trx

  // First and second synchroniser stages for the host pins.
  hmw_host_t host_s1;
  hmw_host_t host_s2;
  // Strobe levels of the previous cycle, for edge detection.
  logic rd_prev;
  logic wr_prev;
  // Mode strap synchroniser stages.
  logic isa_s1;
  logic isa_s2;

  // Next values of the synchroniser and edge-detect stages.
  hmw_host_t next_host_s1;
  hmw_host_t next_host_s2;
  logic next_isa_s1;
  logic next_isa_s2;
  logic next_rd_prev;
  logic next_wr_prev;

  // Only the second stage reads the first; nothing else does.
  always_comb begin
    next_host_s1 = host_pins;
    next_host_s2 = host_s1;
    next_isa_s1 = isa_mode;
    next_isa_s2 = isa_s1;
    next_rd_prev = host_s2.rd;
    next_wr_prev = host_s2.wr;
  end

  // Host pins come from another clock domain; two flops each.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      host_s1 <= '0;
      host_s2 <= '0;
      isa_s1 <= 1'b0;
      isa_s2 <= 1'b0;
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      host_s1 <= next_host_s1;
      host_s2 <= next_host_s2;
      isa_s1 <= next_isa_s1;
      isa_s2 <= next_isa_s2;
      rd_prev <= next_rd_prev;
      wr_prev <= next_wr_prev;
    end
  end

  // One-cycle events on the rising edge of each strobe.
  logic rd_evt;
  logic wr_evt;
  logic [5:0] off;
  logic [7:0] wd;
  assign rd_evt = host_s2.rd & ~rd_prev;
  assign wr_evt = host_s2.wr & ~wr_prev;
  assign off = host_s2.addr;
  assign wd = host_s2.wdata;

  // Bank switch select fields.
  logic capture;
  logic flash_target_select;
  logic [1:0] memory_bank_field;
  logic wide_window_bit;
  logic [1:0] transceiver_bank_field;
  // Next values of the control state.
  logic next_capture;
  logic next_flash;
  logic [1:0] next_mbank;
  logic next_wide;
  logic [1:0] next_tbank;
  logic next_sleep_flag;
  logic next_irq;
  logic next_pd_exit;
  logic [7:0] next_rdata;
  hmw_mem_t next_mem;
  hmw_trx_t next_trx;

  // Local pointer, kept outside every reset.
  logic [PTR_W-1:0] local_pointer;
  logic [PTR_W-1:0] next_ptr;

  // Decoded access kinds for the current event.
  logic dp_hit;
  logic trx_hit;
  logic [7:0] sel_view;
  logic [7:0] ptr_hi_view;
  assign dp_hit = is_dport(off);
  assign trx_hit = is_trx(off, wide_window_bit);

  // Read-back images; the reserved bit stays zero.
  always_comb begin
    sel_view = '0;
    sel_view[`HMW_SEL_CAPTURE] = capture;
    sel_view[`HMW_SEL_FLASH] = flash_target_select;
    sel_view[`HMW_SEL_MBANK_HI:`HMW_SEL_MBANK_LO] = memory_bank_field;
    sel_view[`HMW_SEL_WIDE] = wide_window_bit & ~isa_s2;
    sel_view[`HMW_SEL_TBANK_HI:`HMW_SEL_TBANK_LO] = transceiver_bank_field;
    ptr_hi_view = {1'b0, local_pointer[14:8]};
    // Card mode returns zero in place of undefined data.
    ptr_hi_view[`HMW_PTR_HI_SLEEP] = isa_s2 & pd_active;
  end

  // Pointer: host loads, or steps after each data port access.
  always_comb begin
    next_ptr = local_pointer;
    if (wr_evt && off == `HMW_OFF_PTR_LO) begin
      next_ptr[7:0] = wd;
    end else if (wr_evt && off == `HMW_OFF_PTR_HI) begin
      next_ptr[14:8] = wd[6:0];
    end else if ((wr_evt || rd_evt) && dp_hit) begin
      // The carry out of bit 7 alone steps the high part.
      next_ptr = local_pointer + 15'h0001;
    end
  end

  // No reset branch: the pointer survives every reset.
  always_ff @(posedge mclk) begin
    local_pointer <= next_ptr;
  end

  // Control, status and request generation.
  always_comb begin
    next_capture = capture;
    next_flash = flash_target_select;
    next_mbank = memory_bank_field;
    next_wide = wide_window_bit;
    next_tbank = transceiver_bank_field;
    next_sleep_flag = core_sleep_flag;
    next_irq = 1'b0;
    next_pd_exit = 1'b0;
    next_rdata = host_rdata;
    next_mem = mem_out;
    next_mem.req = 1'b0;
    next_trx = trx_out;
    next_trx.req = 1'b0;
    // Core clears the sleep flag by writing one to it.
    if (core_sleep_clr) begin
      next_sleep_flag = 1'b0;
    end
    if (wr_evt) begin
      // Register writes from the host.
      if (off == `HMW_OFF_BANK_SEL) begin
        // Only a zero clears the capture bit.
        if (!wd[`HMW_SEL_CAPTURE]) begin
          next_capture = 1'b0;
        end
        next_flash = wd[`HMW_SEL_FLASH];
        next_mbank = wd[`HMW_SEL_MBANK_HI:`HMW_SEL_MBANK_LO];
        // The wide bit is frozen at zero in Plug and Play mode.
        if (!isa_s2) begin
          next_wide = wd[`HMW_SEL_WIDE];
        end
        next_tbank = wd[`HMW_SEL_TBANK_HI:`HMW_SEL_TBANK_LO];
      end else if (off == `HMW_OFF_PTR_HI && isa_s2) begin
        // Sleep request only acts in Plug and Play mode.
        if (wd[`HMW_PTR_HI_SLEEP]) begin
          next_sleep_flag = 1'b1;
          next_irq = 1'b1;
        end else if (pd_active) begin
          next_pd_exit = 1'b1;
        end
      end
    end
    if ((wr_evt || rd_evt) && dp_hit) begin
      // Every alias uses the same pointer and bank, no offset.
      next_mem.req = 1'b1;
      next_mem.we = wr_evt;
      next_mem.flash = flash_target_select;
      next_mem.addr = {memory_bank_field, local_pointer};
      next_mem.wdata = wd;
    end
    if ((wr_evt || rd_evt) && trx_hit) begin
      next_trx.req = 1'b1;
      next_trx.we = wr_evt;
      next_trx.wdata = wd;
      if (wide_window_bit) begin
        // Wide window maps the offset straight onto the space.
        next_trx.index = 5'(off - `HMW_OFF_TRX_LO);
      end else begin
        next_trx.index = {transceiver_bank_field, off[2:0]};
      end
    end
    if (rd_evt) begin
      // Read data captured on the rising read strobe.
      if (off == `HMW_OFF_BANK_SEL) begin
        next_rdata = sel_view;
      end else if (off == `HMW_OFF_PTR_LO) begin
        next_rdata = local_pointer[7:0];
      end else if (off == `HMW_OFF_PTR_HI) begin
        next_rdata = ptr_hi_view;
      end else if (dp_hit) begin
        next_rdata = mem_rdata;
      end else if (trx_hit) begin
        next_rdata = trx_rdata;
      end else begin
        // Unmapped offsets read as zero.
        next_rdata = 8'h00;
      end
    end
    // In Plug and Play mode the wide window closes at the next edge, so the
    // decode follows one cycle behind the zero that reads return from the same cycle isa_s2 rises.
    if (isa_s2) begin
      next_wide = 1'b0;
    end
    // A strobe in the clearing cycle still sets the bit.
    if (core_ale) begin
      next_capture = 1'b1;
    end
  end

  // Registers of the control state.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // The capture bit takes its place in the reset image.
      capture <= 1'(`HMW_SEL_RST >> `HMW_SEL_CAPTURE);
      flash_target_select <= 1'b0;
      memory_bank_field <= 2'h0;
      wide_window_bit <= 1'b0;
      transceiver_bank_field <= 2'h0;
      core_sleep_flag <= 1'b0;
      core_irq <= 1'b0;
      pd_exit <= 1'b0;
      host_rdata <= 8'h00;
      mem_out <= '0;
      trx_out <= '0;
    end else begin
      capture <= next_capture;
      flash_target_select <= next_flash;
      memory_bank_field <= next_mbank;
      wide_window_bit <= next_wide;
      transceiver_bank_field <= next_tbank;
      core_sleep_flag <= next_sleep_flag;
      core_irq <= next_irq;
      pd_exit <= next_pd_exit;
      host_rdata <= next_rdata;
      mem_out <= next_mem;
      trx_out <= next_trx;
    end
  end
endmodule : hmw_top

// [testbench/hmw_host.sv]
`timescale 1ns/1ps
// Host model: one byte-wide I/O access per call.
module hmw_host (
  input wire logic mclk,
  output hmw_pkg::hmw_host_t pins
);
  import hmw_pkg::*;
  initial pins = '0;
  // Address and data lead the strobe by two edges and stay put while it is high.
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk) pins <= '{1'b0, 1'b0, a, d};
    repeat (2) @(posedge mclk);
    pins.rd <= !w;
    pins.wr <= w;
    repeat (6) @(posedge mclk);
    pins.rd <= 1'b0;
    pins.wr <= 1'b0;
    pins.wdata <= ~d;
    repeat (3) @(posedge mclk);
  endtask : acc
endmodule : hmw_host

// [testbench/hmw_top_props.sv]
`timescale 1ns/1ps
// Timing checks on the host window, seen from the top ports.
module hmw_top_props #(
  parameter int PTR_W = 15
) (
  input wire logic mclk,
  input wire logic rst,
  input wire hmw_pkg::hmw_host_t host_pins,
  input wire logic isa_mode,
  input wire logic pd_active,
  input wire logic core_sleep_clr,
  input wire hmw_pkg::hmw_mem_t mem_out,
  input wire hmw_pkg::hmw_trx_t trx_out,
  input wire logic [7:0] host_rdata,
  input wire logic core_sleep_flag,
  input wire logic core_irq,
  input wire logic pd_exit
);
  import hmw_pkg::*;
  logic [2:0] w_s, r_s; // Strobe delay lines matching the host synchroniser.
  // Shift the host strobes the way the design samples them.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      w_s <= '0;
      r_s <= '0;
    end else begin
      w_s <= {w_s[1:0], host_pins.wr};
      r_s <= {r_s[1:0], host_pins.rd};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_wev;
    w_s[1] && !w_s[2];
  endsequence
  sequence s_rev;
    r_s[1] && !r_s[2];
  endsequence
  sequence s_dp;
    host_pins.addr inside {[6'h04:6'h07]};
  endsequence
  a_dp_write: assert property ((s_wev ##0 s_dp) |=> mem_out.req && mem_out.we)
    else $error("data port write gave no memory request");
  a_req_cause: assert property (mem_out.req |-> $past(w_s[1] && !w_s[2] || r_s[1] && !r_s[2]))
    else $error("memory request without host access");
  a_req_pulse: assert property (mem_out.req |=> !mem_out.req)
    else $error("memory request longer than one cycle");
  a_trx_narrow: assert property ((s_wev ##0 host_pins.addr inside {[6'h08:6'h0f]})
    |=> trx_out.req && trx_out.index[2:0] == $past(host_pins.addr[2:0]))
    else $error("transceiver access not issued");
  a_irq_flag: assert property (core_irq |-> core_sleep_flag && isa_mode)
    else $error("core interrupt without sleep flag");
  a_irq_pulse: assert property (core_irq |=> !core_irq)
    else $error("core interrupt held");
  a_irq_on_set: assert property ($rose(core_sleep_flag) |-> core_irq)
    else $error("sleep flag set without core interrupt");
  a_wide_isa: assert property ((s_rev ##0 (host_pins.addr == 6'h01 && isa_mode))
    |=> !host_rdata[2])
    else $error("wide window bit read as one in Plug and Play mode");
  a_flag_hold: assert property (core_sleep_flag && !core_sleep_clr |=> core_sleep_flag)
    else $error("sleep flag dropped without core clear");
  a_exit_pd: assert property (pd_exit |-> $past(pd_active) && !$past(pd_exit))
    else $error("wake pulse outside power down");
  a_rdata_hold: assert property (!$past(r_s[1] && !r_s[2]) |-> $stable(host_rdata))
    else $error("read data moved without a read");
endmodule : hmw_top_props
bind hmw_top hmw_top_props #(.PTR_W(PTR_W)) i_props (.mclk(mclk), .rst(rst),
  .host_pins(host_pins), .isa_mode(isa_mode), .pd_active(pd_active),
  .core_sleep_clr(core_sleep_clr), .mem_out(mem_out), .trx_out(trx_out),
  .host_rdata(host_rdata), .core_sleep_flag(core_sleep_flag), .core_irq(core_irq),
  .pd_exit(pd_exit));

// [testbench/tb.sv]
`timescale 1ns/1ps
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb;
  import hmw_pkg::*;
  logic mclk, rst, isa_mode, core_ale, core_sleep_clr, pd_active;
  logic [7:0] mem_rdata, trx_rdata, host_rdata, v, r;
  logic core_sleep_flag, core_irq, pd_exit;
  logic [14:0] p;
  hmw_host_t pins;
  hmw_mem_t mem_out;
  hmw_trx_t trx_out;
  int err_count, n_tests, n_exit, n_irq;
  hmw_host i_host (.mclk(mclk), .pins(pins));
  hmw_top i_hmw_top (.mclk(mclk), .rst(rst), .host_pins(pins), .isa_mode(isa_mode),
    .core_ale(core_ale), .core_sleep_clr(core_sleep_clr), .pd_active(pd_active),
    .mem_rdata(mem_rdata), .trx_rdata(trx_rdata), .mem_out(mem_out), .trx_out(trx_out),
    .host_rdata(host_rdata), .core_sleep_flag(core_sleep_flag), .core_irq(core_irq),
    .pd_exit(pd_exit));
  // Expected view of the control register.
  function automatic logic [7:0] exp_sel(input logic [7:0] w, input logic isa);
    return {2'b00, w[5:3], w[2] & !isa, w[1:0]};
  endfunction : exp_sel
  task automatic rd(input logic [5:0] a);
    i_host.acc(1'b0, a, 8'h00);
    r = host_rdata;
  endtask : rd
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // Wake pulses seen so far.
  always @(posedge mclk) if (pd_exit === 1'b1) n_exit++;
  // Core interrupt pulses seen so far.
  always @(posedge mclk) if (core_irq === 1'b1) n_irq++;
  initial begin
    #200us;
    err_count++;
    end_of_test();
  end
  initial begin
    {rst, isa_mode, core_ale, core_sleep_clr, pd_active} = 5'b10000;
    {mem_rdata, trx_rdata} = '0;
    void'($urandom(32'h90fd_bdd1));
    repeat (2) @(posedge mclk);
    rst <= 0;
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      v[7] = 1'b0;
      i_host.acc(1'b1, 6'h01, v);
      rd(6'h01);
      `CK(r, exp_sel(v, 1'b0))
    end
    @(posedge mclk) core_ale <= 1;
    @(posedge mclk) core_ale <= 0;
    rd(6'h01);
    `CK(r[7], 1'b1)
    i_host.acc(1'b1, 6'h01, v);
    rd(6'h01);
    `CK(r[7], 1'b0)
    for (int k = 0; k < 2; k++) begin
      p = k ? 15'h7ffe : {7'($urandom), 8'hfe};
      i_host.acc(1'b1, 6'h02, p[7:0]);
      i_host.acc(1'b1, 6'h03, {1'b0, p[14:8]});
      for (int i = 0; i < 6; i++) begin
        r = 8'($urandom);
        mem_rdata <= 8'($urandom);
        i_host.acc(i != 5, 6'(4 + i % 4), r);
        `CK(mem_out.addr, {v[4:3], p})
        `CK(mem_out.flash, v[5])
        if (i == 5) `CK(host_rdata, mem_rdata)
        else `CK(mem_out.wdata, r)
        p++;
      end
    end
    for (int i = 0; i < 64; i++) begin
      i_host.acc(1'b1, 6'h01, i < 32 ? 8'(i[4:3]) : 8'h04);
      r = 8'($urandom);
      i_host.acc(1'b1, 6'(i < 32 ? 8 + i % 8 : i - 24), r);
      `CK(trx_out.index, i[4:0])
      `CK(trx_out.wdata, r)
      `CK(trx_out.we, 1'b1)
    end
    trx_rdata <= 8'($urandom);
    rd(6'h0a);
    `CK(r, trx_rdata)
    `CK(trx_out.index, 5'h02)
    `CK(trx_out.we, 1'b0)
    p = 15'($urandom);
    i_host.acc(1'b1, 6'h02, p[7:0]);
    i_host.acc(1'b1, 6'h03, {1'b0, p[14:8]});
    rst <= 1;
    repeat (2) @(posedge mclk);
    rst <= 0;
    i_host.acc(1'b1, 6'h05, 8'h00);
    `CK(mem_out.addr, {2'b00, p})
    i_host.acc(1'b1, 6'h01, 8'h04);
    isa_mode <= 1;
    repeat (4) @(posedge mclk);
    i_host.acc(1'b1, 6'h01, 8'h04);
    rd(6'h01);
    `CK(r[2], 1'b0)
    i_host.acc(1'b1, 6'h10, 8'h5a);
    `CK(trx_out.wdata, 8'h00)
    i_host.acc(1'b1, 6'h03, 8'h80);
    `CK(core_sleep_flag, 1'b1)
    `CK(n_irq, 1)
    rd(6'h03);
    `CK(r[7], 1'b0)
    pd_active <= 1;
    rd(6'h03);
    `CK(r[7], 1'b1)
    i_host.acc(1'b1, 6'h03, 8'h00);
    `CK(n_exit, 1)
    `CK(core_sleep_flag, 1'b1)
    @(posedge mclk) core_sleep_clr <= 1;
    @(posedge mclk) core_sleep_clr <= 0;
    @(posedge mclk);
    `CK(core_sleep_flag, 1'b0)
    end_of_test();
  end
endmodule : tb
